// ---- verilog/irq_time_base.sv ----
/*
  Interrupt request and vectoring logic: three grouped interrupts built
  from timer-module, low-voltage and EEPROM source flags, conversion
  done, two time bases with selectable prescaler clocks, and the serial
  module interrupt. Registers sit on a classic Wishbone slave.
  Assumes: the core pulses irq_take for one cycle while irq_req is high,
  pulses ret_irq on a return-from-interrupt, and drives stack_full from
  its own logic; sub_clk is an asynchronous slow clock pin.
*/
// The register offsets and register access over Wishbone are this design's own decisions.
//
// Contract
// - three grouped interrupts from timer, low-voltage and EEPROM flags
// - grouped flag sets when any of its source flags becomes set
// - grouped vector needs its enable, free stack and a requesting source
// - grouped service clears its grouped flag and the global enable
// - conversion done flag sets when a conversion completes
// - conversion vector needs global and own enable and free stack
// - conversion service clears its flag and the global enable
// - each tick flag sets on its own time base overflow
// - tick vector needs global and own enable, free stack; service clears
// - clock source 00 system, 01 system/4, 1x sub clock; resets zero
// - time base 1 period is 2^(8+field) prescaler clocks
// - time base 0 period field selects 2^8 to 2^15 prescaler clocks
// - unused prescaler and time base control bits read as zero
// - each timer module raises match A and match P requests
// - timer vector needs global, own and grouped enable, free stack
// - serial flag sets on byte done, address match or bus timeout
// - serial vector needs global and own enable; service clears its flag and the global enable
// - full stack blocks every interrupt acknowledge
// - any request flag rising wakes the device, enabled or not
// - return from interrupt sets the global enable again
`timescale 1ns/10ps

module irq_time_base
  import irq_pkg::*;
(
  input  wire logic               sys_clk,
  input  wire logic               rst_b,
  input  wire irq_pkg::wb_req_t   wb_req,
  output      irq_pkg::wb_rsp_t   wb_rsp,
  input  wire irq_pkg::src_evt_t  src_evt,
  input  wire logic               sub_clk,
  input  wire logic               stack_full,
  input  wire logic               irq_take,
  input  wire logic               ret_irq,
  output      irq_pkg::core_irq_t core_irq,
  output      logic               wake
);
  import irq_pkg::*;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  state_t              st;
  state_t              next_st;
  logic [1:0]          ovf;
  logic [1:0]          psc_en;
  logic                sub_edge;
  logic                req_hit;
  logic                wr_hit;
  logic [7:0]          src_rise;
  logic [2:0]          grp_hit;
  logic [NUM_VEC-1:0]  pend;

  // last count of a period: 2^(8+sel) - 1
  function automatic logic [14:0] period_last(input logic [2:0] sel);
    logic [15:0] span;
    span = PERIOD_BASE << sel;
    return span[14:0] - 15'h0001;
  endfunction : period_last

  // prescaler clock enable from its source field
  function automatic logic psc_tick(input logic [1:0] src,
                                    input logic       d4,
                                    input logic       sub);
    logic t;
    t = sub;
    if (src == PSC_SYS)
      t = 1'b1;
    else if (src == PSC_SYS_D4)
      t = d4;
    return t;
  endfunction : psc_tick

  // lowest set index wins, i.e. the lowest vector address
  function automatic logic [2:0] first_set(input logic [NUM_VEC-1:0] p);
    logic [2:0] idx;
    idx = 3'h0;
    for (int k = NUM_VEC - 1; k >= 0; k--) begin
      if (p[k])
        idx = 3'(k);
    end
    return idx;
  endfunction : first_set

  // every request flag, used to see any of them rise
  function automatic logic [14:0] all_flags(input state_t s);
    return {s.src_flag, s.ser_flag, s.tick_flag, s.conv_flag, s.grp_flag};
  endfunction : all_flags

  // register read; unused bits come back zero
  function automatic logic [31:0] reg_read(input state_t s,
                                           input logic [ADR_W-1:0] a);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      OFS_PSC0:     v = {6'h00, s.psc_sel[0]};
      OFS_PSC1:     v = {6'h00, s.psc_sel[1]};
      OFS_TIME_BASE0_CONTROL:     v = {s.tb_run[0], 4'h0, s.tb_period[0]};
      OFS_TIME_BASE1_CONTROL:     v = {s.tb_run[1], 4'h0, s.tb_period[1]};
      OFS_IRQ_CTRL: v = {s.ser_en, s.tick_en, s.conv_en, s.grp_en, s.gie};
      OFS_IRQ_FLAG: v = {1'b0, s.ser_flag, s.tick_flag, s.conv_flag,
                         s.grp_flag};
      OFS_SRC_FLAG: v = s.src_flag;
      OFS_SRC_EN:   v = s.src_en;
      default:      v = 8'h00;                      // unmapped reads zero
    endcase
    return {24'h000000, v};
  endfunction : reg_read

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  // order inside: bus write, return, service clear, hardware sets;
  // the sets come last so an event in a clearing cycle is never lost
  always_comb begin
    next_st  = st;
    ovf      = 2'b00;
    psc_en   = 2'b00;
    src_rise = 8'h00;
    grp_hit  = 3'b000;
    pend     = '0;
    req_hit  = wb_req.cyc & wb_req.stb & ~st.ack;
    wr_hit   = req_hit & wb_req.we & wb_req.sel[0];
    sub_edge = st.sub_sync[1] & ~st.sub_sync[2];

    // bus slave: answer one cycle after the request is seen
    next_st.ack = req_hit;
    if (req_hit)
      next_st.rdata = reg_read(st, wb_req.adr);
    if (wr_hit) begin
      unique case (wb_req.adr)
        OFS_PSC0: next_st.psc_sel[0] = wb_req.dat[1:0];
        OFS_PSC1: next_st.psc_sel[1] = wb_req.dat[1:0];
        OFS_TIME_BASE0_CONTROL: begin
          next_st.tb_run[0]    = wb_req.dat[TBC_RUN];
          next_st.tb_period[0] = wb_req.dat[2:0];
        end
        OFS_TIME_BASE1_CONTROL: begin
          next_st.tb_run[1]    = wb_req.dat[TBC_RUN];
          next_st.tb_period[1] = wb_req.dat[2:0];
        end
        OFS_IRQ_CTRL: begin
          next_st.gie     = wb_req.dat[CTRL_GIE];
          next_st.grp_en  = wb_req.dat[CTRL_GRP_EN +: 3];
          next_st.conv_en = wb_req.dat[CTRL_CONV_EN];
          next_st.tick_en = wb_req.dat[CTRL_TICK_EN +: 2];
          next_st.ser_en  = wb_req.dat[CTRL_SER_EN];
        end
        OFS_IRQ_FLAG: begin
          next_st.grp_flag  = wb_req.dat[FLAG_GRP +: 3];
          next_st.conv_flag = wb_req.dat[FLAG_CONV];
          next_st.tick_flag = wb_req.dat[FLAG_TICK +: 2];
          next_st.ser_flag  = wb_req.dat[FLAG_SER];
        end
        OFS_SRC_FLAG: next_st.src_flag = wb_req.dat[7:0];
        OFS_SRC_EN:   next_st.src_en   = wb_req.dat[7:0];
        default: ;                              // unmapped writes dropped
      endcase
    end

    // a return from interrupt reopens the global enable
    if (ret_irq)
      next_st.gie = 1'b1;

    // service: clear only the taken flag; source flags stay for software
    if (irq_take && st.irq_req) begin
      next_st.gie = 1'b0;
      if (st.vec_sel < IDX_CONV)
        next_st.grp_flag[st.vec_sel[1:0]] = 1'b0;
      else if (st.vec_sel == IDX_CONV)
        next_st.conv_flag = 1'b0;
      else if (st.vec_sel == IDX_TB0)
        next_st.tick_flag[0] = 1'b0;
      else if (st.vec_sel == IDX_TB1)
        next_st.tick_flag[1] = 1'b0;
      else
        next_st.ser_flag = 1'b0;
    end

    // prescaler sources: free divide by four and synchronised sub clock
    next_st.div4     = st.div4 + 2'h1;
    next_st.sub_sync = {st.sub_sync[1:0], sub_clk};
    for (int i = 0; i < 2; i++) begin
      psc_en[i] = psc_tick(st.psc_sel[i], st.div4 == DIV4_LAST, sub_edge);
      if (!st.tb_run[i]) begin
        next_st.tb_cnt[i] = 15'h0000;
      end else if (psc_en[i]) begin
        // >= keeps a shortened period from running past its end
        if (st.tb_cnt[i] >= period_last(st.tb_period[i])) begin
          next_st.tb_cnt[i] = 15'h0000;
          ovf[i]            = 1'b1;
        end else begin
          next_st.tb_cnt[i] = st.tb_cnt[i] + 15'h0001;
        end
      end
    end

    // hardware sets win over any clear in the same cycle
    next_st.src_flag = next_st.src_flag |
      {src_evt.eeprom_evt, src_evt.lvd_evt,
       src_evt.tm_match_p, src_evt.tm_match_a};
    src_rise = next_st.src_flag & ~st.src_flag;
    for (int k = 0; k < 3; k++)
      grp_hit[k] = |(src_rise & GROUP_MASK[k]);
    next_st.grp_flag  = next_st.grp_flag | grp_hit;
    next_st.conv_flag = next_st.conv_flag | src_evt.conv_done;
    next_st.tick_flag = next_st.tick_flag | ovf;
    next_st.ser_flag  = next_st.ser_flag | src_evt.ser_byte_done |
      src_evt.ser_addr_match | src_evt.ser_timeout;

    // pending vectors, judged on the state about to be stored
    for (int k = 0; k < 3; k++)
      pend[k] = next_st.gie & next_st.grp_en[k] & next_st.grp_flag[k] &
        |(next_st.src_flag & next_st.src_en & GROUP_MASK[k]);
    pend[IDX_CONV] = next_st.gie & next_st.conv_en &
                     next_st.conv_flag;
    pend[IDX_TB0]  = next_st.gie & next_st.tick_en[0] &
                     next_st.tick_flag[0];
    pend[IDX_TB1]  = next_st.gie & next_st.tick_en[1] &
                     next_st.tick_flag[1];
    pend[IDX_SER]  = next_st.gie & next_st.ser_en &
                     next_st.ser_flag;
    next_st.irq_req = (|pend) & ~stack_full;
    next_st.vec_sel = first_set(pend);
    next_st.vector  = VEC_ADDR[next_st.vec_sel];

    // wake ignores every enable on purpose
    next_st.wake = |(all_flags(next_st) & ~all_flags(st));
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  // synchronous reset to constants; outputs are all registered
  always_ff @(posedge sys_clk) begin
    if (!rst_b)
      st <= STATE_RESET;
    else
      st <= next_st;
  end

  assign wb_rsp.ack      = st.ack;
  assign wb_rsp.dat      = st.rdata;
  assign core_irq.req    = st.irq_req;
  assign core_irq.vector = st.vector;
  assign wake            = st.wake;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  chk_stack_blocks_ack: assert property (
    stack_full |=> !core_irq.req)
    else $error("request raised while the stack was full");

  chk_conv_flag_set: assert property (
    src_evt.conv_done |=> st.conv_flag)
    else $error("conversion done did not set its flag");

  chk_tick_on_ovf: assert property (
    ovf[0] |=> st.tick_flag[0])
    else $error("time base overflow did not set its flag");

  chk_serial_sets: assert property (
    (src_evt.ser_byte_done || src_evt.ser_timeout) |=> st.ser_flag)
    else $error("serial event did not set its flag");

  chk_req_needs_gie: assert property (
    core_irq.req |-> st.gie)
    else $error("request raised with global enable low");

  chk_take_clears_gie: assert property (
    (irq_take && core_irq.req && !ret_irq && !wr_hit)
      |=> !st.gie && !core_irq.req)
    else $error("service left global enable or request high");

  chk_return_from_interrupt_sets_gie: assert property (
    (ret_irq && !irq_take && !wr_hit) |=> st.gie)
    else $error("return from interrupt left global enable low");

  chk_group_sets: assert property (
    (src_evt.lvd_evt && !st.src_flag[6]) |=> st.grp_flag[2])
    else $error("grouped flag missed a rising source flag");

  chk_wake_pulse: assert property (
    (src_evt.conv_done && !st.conv_flag) |=> wake ##1 !wake)
    else $error("rising flag gave no single wake pulse");

  chk_unused_zero: assert property (
    $rose(wb_rsp.ack) && !$past(wb_req.we) &&
      ($past(wb_req.adr) == OFS_TIME_BASE0_CONTROL) |-> wb_rsp.dat[6:3] == 4'h0)
    else $error("unused time base control bits read nonzero");

  chk_tb_restart: assert property (
    !st.tb_run[0] |=> st.tb_cnt[0] == 15'h0000)
    else $error("stopped time base kept counting");

  chk_tb1_restart: assert property (
    !st.tb_run[1] |=> st.tb_cnt[1] == 15'h0000)
    else $error("stopped time base 1 kept counting");

  // a sub clock source ticks rarely; between
  // its edges the count must not move
  chk_sub_holds_cnt: assert property (
    st.tb_run[0] && st.psc_sel[0][1] && !sub_edge
      |=> st.tb_cnt[0] == $past(st.tb_cnt[0]))
    else $error("time base moved without a sub edge");

  // no period is shorter than 2^8 ticks
  chk_tb1_min_span: assert property (
    ovf[1] |-> {1'b0, st.tb_cnt[1]} >= PERIOD_BASE - 16'h0001)
    else $error("time base 1 overflowed too early");

  chk_tick1_on_ovf: assert property (
    ovf[1] |=> st.tick_flag[1])
    else $error("time base 1 overflow set no flag");

  // service and priority; an event or a bus write
  // in the take cycle may set the flag again,
  // so those cycles are left out
  chk_conv_take_clr: assert property (
    irq_take && core_irq.req && st.vec_sel == IDX_CONV &&
      !wr_hit && !src_evt.conv_done |=> !st.conv_flag)
    else $error("conversion service left its flag");

  chk_tick_take_clr: assert property (
    irq_take && core_irq.req && st.vec_sel == IDX_TB0 &&
      !wr_hit && !ovf[0] |=> !st.tick_flag[0])
    else $error("time base service left its flag");

  // only software may lower a source flag
  chk_take_keeps_src: assert property (
    irq_take && core_irq.req && !wr_hit
      |=> ($past(st.src_flag) & ~st.src_flag) == 8'h00)
    else $error("service cleared a source flag");

  chk_grp0_needs_src: assert property (
    core_irq.req && core_irq.vector == VEC_ADDR[0]
      |-> st.grp_en[0] && st.grp_flag[0] &&
          |(st.src_flag & st.src_en & GROUP_MASK[0]))
    else $error("grouped vector without enabled source");

  chk_conv_priority: assert property (
    core_irq.req && st.conv_en && st.conv_flag
      |-> core_irq.vector <= VEC_ADDR[IDX_CONV])
    else $error("lower vector shown over conversion");

  // bus answers: one-cycle ack, so a held
  // request is never acked twice in a row
  chk_ack_single: assert property (
    wb_rsp.ack |=> !wb_rsp.ack)
    else $error("bus ack stood two cycles");

  chk_psc_unused_zero: assert property (
    $rose(wb_rsp.ack) && !$past(wb_req.we) &&
      ($past(wb_req.adr) == OFS_PSC1) |-> wb_rsp.dat[7:2] == 6'h00)
    else $error("unused prescaler bits read nonzero");

endmodule : irq_time_base

// ---- include/irq_pkg.sv ----
/*
  Shared types and constants of the interrupt controller with two time
  bases: bus carriers, register offsets, field positions, vector table
  and the packed state of the controller.
  Assumes a 32-bit classic Wishbone bus with byte addresses.
*/
package irq_pkg;

  // ---------------------------------------------------------------
  // bus and port carriers
  // ---------------------------------------------------------------
  localparam int ADR_W = 8;

  typedef struct packed {
    logic             cyc;
    logic             stb;
    logic             we;
    logic [ADR_W-1:0] adr;
    logic [3:0]       sel;
    logic [31:0]      dat;
  } wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_t;

  // one-cycle event pulses from the peripherals, same clock
  typedef struct packed {
    logic [2:0] tm_match_a;
    logic [2:0] tm_match_p;
    logic       lvd_evt;
    logic       eeprom_evt;
    logic       conv_done;
    logic       ser_byte_done;
    logic       ser_addr_match;
    logic       ser_timeout;
  } src_evt_t;

  typedef struct packed {
    logic       req;
    logic [7:0] vector;
  } core_irq_t;

  // ---------------------------------------------------------------
  // register map (byte offsets) and fields
  // ---------------------------------------------------------------
  localparam logic [ADR_W-1:0] OFS_PSC0     = 8'h00;
  localparam logic [ADR_W-1:0] OFS_PSC1     = 8'h04;
  localparam logic [ADR_W-1:0] OFS_TIME_BASE0_CONTROL     = 8'h08;
  localparam logic [ADR_W-1:0] OFS_TIME_BASE1_CONTROL     = 8'h0C;
  localparam logic [ADR_W-1:0] OFS_IRQ_CTRL = 8'h10;
  localparam logic [ADR_W-1:0] OFS_IRQ_FLAG = 8'h14;
  localparam logic [ADR_W-1:0] OFS_SRC_FLAG = 8'h18;
  localparam logic [ADR_W-1:0] OFS_SRC_EN   = 8'h1C;

  localparam int TBC_RUN      = 7;
  localparam int CTRL_GIE     = 0;
  localparam int CTRL_GRP_EN  = 1;
  localparam int CTRL_CONV_EN = 4;
  localparam int CTRL_TICK_EN = 5;
  localparam int CTRL_SER_EN  = 7;
  localparam int FLAG_GRP     = 0;
  localparam int FLAG_CONV    = 3;
  localparam int FLAG_TICK    = 4;
  localparam int FLAG_SER     = 6;

  localparam logic [7:0]  REG_RESET   = 8'h00;
  localparam logic [1:0]  PSC_SYS     = 2'h0;
  localparam logic [1:0]  PSC_SYS_D4  = 2'h1;
  localparam logic [1:0]  DIV4_LAST   = 2'h3;
  localparam logic [15:0] PERIOD_BASE = 16'h0100;  // 2^8 prescaler ticks

  // ---------------------------------------------------------------
  // vectors, lowest index has highest priority
  // ---------------------------------------------------------------
  localparam int NUM_VEC = 7;
  localparam logic [2:0] IDX_CONV = 3'h3;
  localparam logic [2:0] IDX_TB0  = 3'h4;
  localparam logic [2:0] IDX_TB1  = 3'h5;
  localparam logic [2:0] IDX_SER  = 3'h6;
  localparam logic [NUM_VEC-1:0][7:0] VEC_ADDR =
    {8'h24, 8'h20, 8'h1C, 8'h18, 8'h14, 8'h10, 8'h0C};
  // source flag bits: [2:0] match A, [5:3] match P, 6 lvd, 7 eeprom
  localparam logic [2:0][7:0] GROUP_MASK = {8'hC0, 8'h36, 8'h09};

  // ---------------------------------------------------------------
  // packed controller state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0][1:0]  psc_sel;
    logic [1:0]       tb_run;
    logic [1:0][2:0]  tb_period;
    logic             gie;
    logic [2:0]       grp_en;
    logic             conv_en;
    logic [1:0]       tick_en;
    logic             ser_en;
    logic [2:0]       grp_flag;
    logic             conv_flag;
    logic [1:0]       tick_flag;
    logic             ser_flag;
    logic [7:0]       src_flag;
    logic [7:0]       src_en;
    logic [1:0][14:0] tb_cnt;
    logic [1:0]       div4;
    logic [2:0]       sub_sync;
    logic             ack;
    logic [31:0]      rdata;
    logic             irq_req;
    logic [2:0]       vec_sel;
    logic [7:0]       vector;
    logic             wake;
  } state_t;

  localparam state_t STATE_RESET = '0;

endpackage : irq_pkg

// ---- tb/core_model.sv ----
/*
  Behavioural processor core beside the interrupt controller: takes a
  pending vector, runs a service of ret_gap + 1 cycles, then returns.
  Assumes the core link shares sys_clk with the controller.
*/
`timescale 1ns/10ps

module core_model
  import irq_pkg::*;
(
  input  wire logic               sys_clk,
  input  wire logic               rst_b,
  input  wire irq_pkg::core_irq_t core_irq,
  input  wire logic               hold_stack,
  input  wire logic [7:0]         ret_gap,
  output      logic               stack_full,
  output      logic               irq_take,
  output      logic               ret_irq
);
  import irq_pkg::*;

  logic       busy;
  logic [7:0] cnt;

  // -----------------------------------------------------------------
  // take, serve, return
  // -----------------------------------------------------------------
  // no take while the stack is full, so a held stack cannot race a take
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      stack_full <= 1'b0;
      irq_take   <= 1'b0;
      ret_irq    <= 1'b0;
      busy       <= 1'b0;
      cnt        <= 8'h00;
    end else begin
      stack_full <= hold_stack;
      ret_irq    <= 1'b0;
      if (irq_take) begin
        irq_take <= 1'b0;
        busy     <= 1'b1;
        cnt      <= 8'h00;
      end else if (busy) begin
        cnt <= cnt + 8'h01;
        if (cnt == ret_gap) begin
          busy    <= 1'b0;
          ret_irq <= 1'b1;  // return that re-enables
        end
      end else if (core_irq.req && !stack_full) begin
        irq_take <= 1'b1;
      end
    end
  end

endmodule : core_model

// ---- tb/testbench.sv ----
/*
  Self-checking bench of the interrupt controller: Wishbone register
  traffic, source events, a core model and a free sub clock.
  Assumes the controller and the core model share sys_clk.
*/
`timescale 1ns/10ps

module testbench;
  import irq_pkg::*;

  logic        sys_clk = 1'b0;
  logic        sub_clk = 1'b0;
  logic        rst_b, hold_stack, stack_full, irq_take, ret_irq, wake;
  logic [7:0]  ret_gap;
  logic [31:0] rnd;
  integer      seed;
  wb_req_t     wb_req;
  wb_rsp_t     wb_rsp;
  src_evt_t    src_evt, e;
  core_irq_t   core_irq;
  int          err_count, check_count, take_n, wake_n, cyc_n, t, g, d;
  logic [31:0] rd_q[$];
  logic [7:0]  vec_q[$];
  int          take_cyc[$];
  logic [7:0]  ofs[4] = '{OFS_PSC0, OFS_PSC1, OFS_TIME_BASE0_CONTROL, OFS_TIME_BASE1_CONTROL};
  logic [7:0]  msk[4] = '{8'h03, 8'h03, 8'h87, 8'h87};
  int          tb_i[4] = '{0, 1, 0, 1};
  logic [1:0]  tb_s[4] = '{2'h0, 2'h1, 2'h0, 2'h2};
  logic [2:0]  tb_p[4] = '{3'h0, 3'h1, 3'h3, 3'h0};
  int          tb_n[4] = '{256, 2048, 2048, 2579};

  // clocks; the sub clock period is unrelated to the system clock
  always #20 sys_clk = ~sys_clk;
  always #201.5 sub_clk = ~sub_clk;

  irq_time_base dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .wb_req(wb_req),
    .wb_rsp(wb_rsp), .src_evt(src_evt), .sub_clk(sub_clk),
    .stack_full(stack_full), .irq_take(irq_take), .ret_irq(ret_irq),
    .core_irq(core_irq), .wake(wake));

  core_model core_u (.sys_clk(sys_clk), .rst_b(rst_b), .core_irq(core_irq),
    .hold_stack(hold_stack), .ret_gap(ret_gap), .stack_full(stack_full),
    .irq_take(irq_take), .ret_irq(ret_irq));

  // -----------------------------------------------------------------
  // reporting
  // -----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report

  // -----------------------------------------------------------------
  // drivers
  // -----------------------------------------------------------------
  // one classic cycle; a read notes its expected data for the watcher
  task automatic bus(input logic we, input logic [7:0] adr,
                     input logic [7:0] wd, input logic [7:0] exp);
    int n;
    @(posedge sys_clk);
    wb_req <= '{1'b1, 1'b1, we, adr, 4'hF, {24'h0, wd}};
    if (!we) rd_q.push_back({24'h0, exp});
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_rsp.ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_count++;
      $display("FAIL t=%0t no bus answer", $time);
    end
    wb_req <= '0;
  endtask : bus

  task automatic pulse(input src_evt_t ev);
    @(posedge sys_clk);
    src_evt <= ev;
    @(posedge sys_clk);
    src_evt <= '0;
  endtask : pulse

  task automatic wait_take(input int n);
    int k;
    k = 0;
    while (take_n < n && k < 9000) begin
      @(posedge sys_clk);
      k++;
    end
    if (take_n < n) begin
      err_count++;
      $display("FAIL t=%0t no vector taken", $time);
    end
  endtask : wait_take

  // clear flags and let any pending return land
  task automatic settle(input string s);
    bus(1'b1, OFS_SRC_FLAG, 8'h00, 8'h00);
    bus(1'b1, OFS_IRQ_FLAG, 8'h00, 8'h00);
    repeat (int'(ret_gap) + 4) @(posedge sys_clk);
    $display("test %0s done", s);
  endtask : settle

  // -----------------------------------------------------------------
  // watcher: pairs each answer with the oldest note
  // -----------------------------------------------------------------
  always @(posedge sys_clk) begin
    cyc_n++;
    if (wake === 1'b1) wake_n++;
    if (wb_rsp.ack === 1'b1 && wb_req.cyc && !wb_req.we)
      check(wb_rsp.dat, rd_q.pop_front());
    if (irq_take === 1'b1 && core_irq.req === 1'b1) begin
      take_n++;
      take_cyc.push_back(cyc_n);
      check({24'h0, core_irq.vector}, {24'h0, vec_q.pop_front()});
    end
  end

  // watchdog sized well above the longest time base sequence
  initial begin
    #3200000;
    err_count++;
    $display("FAIL t=%0t watchdog", $time);
    final_report();
  end

  // -----------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    wb_req = '0;
    src_evt = '0;
    hold_stack = 1'b0;
    ret_gap = 8'h08;
    seed = 32'hA9D9EBC3;
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    rnd = $random(seed);
    ret_gap <= 8'h08 + {3'h0, rnd[4:0]};
    // reset values, unused bits, unmapped place
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, ofs[i], 8'h00, 8'h00);
      rnd = $random(seed);
      bus(1'b1, ofs[i], rnd[7:0], 8'h00);
      bus(1'b0, ofs[i], 8'h00, rnd[7:0] & msk[i]);
      bus(1'b1, ofs[i], 8'h00, 8'h00);
    end
    bus(1'b1, 8'h20, 8'hFF, 8'h00);
    bus(1'b0, 8'h20, 8'h00, 8'h00);
    settle("registers");
    // conversion: gated by global enable and stack, then served
    bus(1'b1, OFS_IRQ_CTRL, 8'h10, 8'h00);
    t = take_n;
    pulse(src_evt_t'(12'h008));
    repeat (10) @(posedge sys_clk);
    check(take_n - t, 0);
    bus(1'b0, OFS_IRQ_FLAG, 8'h00, 8'h08);
    hold_stack <= 1'b1;
    bus(1'b1, OFS_IRQ_CTRL, 8'h11, 8'h00);
    repeat (10) @(posedge sys_clk);
    check(take_n - t, 0);
    vec_q.push_back(8'h18);
    hold_stack <= 1'b0;
    wait_take(t + 1);
    bus(1'b0, OFS_IRQ_CTRL, 8'h00, 8'h10);
    bus(1'b0, OFS_IRQ_FLAG, 8'h00, 8'h00);
    repeat (int'(ret_gap) + 4) @(posedge sys_clk);
    bus(1'b0, OFS_IRQ_CTRL, 8'h00, 8'h11);
    settle("conversion");
    // grouped: flag without source enable, then each source alone
    bus(1'b1, OFS_IRQ_CTRL, 8'h0F, 8'h00);
    bus(1'b1, OFS_SRC_EN, 8'h00, 8'h00);
    t = take_n;
    e = '0;
    e.tm_match_a[1] = 1'b1;
    pulse(e);
    repeat (10) @(posedge sys_clk);
    check(take_n - t, 0);
    bus(1'b0, OFS_IRQ_FLAG, 8'h00, 8'h02);
    settle("group gate");
    for (int i = 0; i < 8; i++) begin
      g = (i >= 6) ? 2 : ((i % 3 == 0) ? 0 : 1);
      e = '0;
      if (i < 3) e.tm_match_a[i] = 1'b1;
      else if (i < 6) e.tm_match_p[i-3] = 1'b1;
      else if (i == 6) e.lvd_evt = 1'b1;
      else e.eeprom_evt = 1'b1;
      bus(1'b1, OFS_IRQ_CTRL, 8'h0F, 8'h00);
      bus(1'b1, OFS_SRC_EN, 8'h01 << i, 8'h00);
      vec_q.push_back(8'h0C + 8'(4 * g));
      t = take_n;
      pulse(e);
      wait_take(t + 1);
      bus(1'b0, OFS_SRC_FLAG, 8'h00, 8'h01 << i);
      bus(1'b0, OFS_IRQ_FLAG, 8'h00, 8'h00);
      settle("group source");
    end
    // serial module, each cause
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, OFS_IRQ_CTRL, 8'h81, 8'h00);
      vec_q.push_back(8'h24);
      t = take_n;
      pulse(src_evt_t'(12'h001 << i));
      wait_take(t + 1);
      bus(1'b0, OFS_IRQ_FLAG, 8'h00, 8'h00);
      settle("serial");
    end
    // two at once: lower vector address first
    bus(1'b1, OFS_IRQ_CTRL, 8'h91, 8'h00);
    vec_q.push_back(8'h18);
    vec_q.push_back(8'h24);
    t = take_n;
    pulse(src_evt_t'(12'h009));
    wait_take(t + 2);
    settle("priority");
    // wake on a rising flag only, enables off
    bus(1'b1, OFS_IRQ_CTRL, 8'h00, 8'h00);
    for (int i = 0; i < 2; i++) begin
      d = wake_n;
      pulse(src_evt_t'(12'h020));
      repeat (4) @(posedge sys_clk);
      check(wake_n - d, 1 - i);
    end
    settle("wake");
    // time bases: period per source and field
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, OFS_IRQ_CTRL, 8'h61, 8'h00);
      bus(1'b1, ofs[tb_i[i]], {6'h00, tb_s[i]}, 8'h00);
      vec_q.push_back(8'h1C + 8'(4 * tb_i[i]));
      vec_q.push_back(8'h1C + 8'(4 * tb_i[i]));
      t = take_n;
      bus(1'b1, ofs[tb_i[i] + 2], {5'h10, tb_p[i]}, 8'h00);
      wait_take(t + 2);
      d = take_cyc[$] - take_cyc[$-1];
      if (i == 3) check(d >= 2576 && d <= 2582, 1);
      else check(d, tb_n[i]);
      bus(1'b1, ofs[tb_i[i] + 2], 8'h00, 8'h00);
      settle("time base");
    end
    final_report();
  end

endmodule : testbench
